// ### ssr_status.sv
// status byte, standard event register, enable masks and query answers
`timescale 1ns/100ps
// How it works
// - quench bit latches, message bit follows the buffer each cycle unless clear-status holds it low until empty; reading never changes them
// - queries return the register's bit-weighted sum, also as decimal digits
// - event bits latch on first occurrence, hold until read or clear-status
// - enable masks are written and read; masked events feed summary bits
// - clear-status clears events and status byte but leaves every mask
// - quench weight 4, serial message 8, event summary 32, summary 64
// - serial message bit sets as soon as the output buffer holds data
// - clearing event bits recomputes the event summary from remaining bits
// - quench flag holds until cleared from panel or by remote command
// - message bit holds until the output buffer is fully read out or clear-status comes
// - clear-status clears status byte; event read clears bit 5, and bit 6 if bit 5 alone set it
// - writing zero clears a mask; power-on clears it when setting is 1
// - keywords pass only in full or short form, otherwise an error
// - status byte query returns the whole byte and keeps bit 6
// - standard event register clears on clear-status and on its query
module ssr_status (
	input  wire logic                   ref_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   cmd_valid_i,
	input  wire ssr_pkg::ssr_op_t       cmd_op_i,
	input  wire logic [7:0]             cmd_data_i,
	input  wire logic [7:0]             event_i,
	input  wire logic                   power_on_i,
	input  wire logic                   quench_detect_i,
	input  wire logic                   quench_reset_i,
	input  wire logic                   ser_not_empty_i,
	input  wire logic                   ch_valid_i,
	input  wire logic [7:0]             ch_i,
	input  wire logic                   kw_end_i,
	output logic [7:0]                  status_byte_o,
	output logic                        rsp_valid_o,
	output logic [7:0]                  rsp_value_o,
	output logic [11:0]                 rsp_dec_o
);
	import ssr_pkg::*;

	logic [7:0]  stb;
	logic [7:0]  esr;
	logic [7:0]  ese;
	logic [7:0]  sre;
	logic        psc;
	logic        quench;
	logic        smav_block;
	logic        rsp_valid;
	logic [7:0]  rsp_value;
	logic [11:0] rsp_dec;
	logic [7:0]  next_stb;
	logic [7:0]  next_esr;
	logic [7:0]  next_ese;
	logic [7:0]  next_sre;
	logic        next_psc;
	logic        next_quench;
	logic        next_smav_block;
	logic        next_rsp_valid;
	logic [7:0]  next_rsp_value;
	logic [11:0] next_rsp_dec;
	logic        kw_err;
	logic [7:0]  ev;
	logic        do_cls;
	logic        do_esr_q;

	// binary value to three decimal digits
	function automatic logic [11:0] to_dec(input logic [7:0] v);
		logic [7:0] h;
		logic [7:0] t;
		logic [7:0] o;
		h = v / 8'd100;
		t = (v % 8'd100) / 8'd10;
		o = v % 8'd10;
		return {h[3:0], t[3:0], o[3:0]};
	endfunction

	ssr_kwchk u_kwchk (
		.ref_clk_i  (ref_clk_i),
		.resetn_i   (resetn_i),
		.ch_valid_i (ch_valid_i),
		.ch_i       (ch_i),
		.kw_end_i   (kw_end_i),
		.kw_ok_o    (),
		.kw_err_o   (kw_err)
	);

	assign do_cls = cmd_valid_i && cmd_op_i == SSR_OP_CLS;
	assign do_esr_q = cmd_valid_i && cmd_op_i == SSR_OP_ESR_Q;

	// events from the instrument, the parser and power-up
	always_comb begin
		ev = event_i & ESR_USED_MASK;
		ev[ESR_CME_POS] = ev[ESR_CME_POS] | kw_err;
		ev[ESR_PON_POS] = ev[ESR_PON_POS] | power_on_i;
	end

	// standard event register and masks
	always_comb begin
		next_esr = esr;
		next_ese = ese;
		next_sre = sre;
		next_psc = psc;
		if (do_cls || do_esr_q) begin
			next_esr = 8'h00;
		end
		next_esr = next_esr | ev;
		if (cmd_valid_i) begin
			case (cmd_op_i)
				SSR_OP_ESE_W: begin
					next_ese = cmd_data_i;
				end
				SSR_OP_SRE_W: begin
					next_sre = cmd_data_i & SRE_WR_MASK;
				end
				SSR_OP_PSC_W: begin
					next_psc = cmd_data_i[0];
				end
				default: begin
					next_psc = psc;
				end
			endcase
		end
		if (power_on_i && psc) begin
			next_ese = 8'h00;
			next_sre = 8'h00;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			esr <= ESR_RESET;
			ese <= ESE_RESET;
			sre <= SRE_RESET;
			psc <= PSC_RESET;
		end else begin
			esr <= next_esr;
			ese <= next_ese;
			sre <= next_sre;
			psc <= next_psc;
		end
	end

	// status byte conditions and summaries
	always_comb begin
		logic [7:0] low;
		low = 8'h00;
		next_quench = quench;
		next_smav_block = smav_block;
		if (quench_reset_i || do_cls) begin
			next_quench = 1'b0;
		end
		if (quench_detect_i) begin
			next_quench = 1'b1;
		end
		if (!ser_not_empty_i) begin
			next_smav_block = 1'b0;
		end else if (do_cls) begin
			next_smav_block = 1'b1;
		end
		low[STB_QUENCH_POS] = next_quench;
		low[STB_SMAV_POS] = ser_not_empty_i && !next_smav_block;
		low[STB_ESB_POS] = |(next_esr & next_ese);
		next_stb = low;
		next_stb[STB_RQS_POS] = |(low & next_sre);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stb <= STB_RESET;
			quench <= 1'b0;
			smav_block <= 1'b0;
		end else begin
			stb <= next_stb;
			quench <= next_quench;
			smav_block <= next_smav_block;
		end
	end

	// query answers, one per command, in command order
	always_comb begin
		next_rsp_valid = 1'b0;
		next_rsp_value = rsp_value;
		if (cmd_valid_i) begin
			case (cmd_op_i)
				SSR_OP_STB_Q: begin
					next_rsp_valid = 1'b1;
					next_rsp_value = stb;
				end
				SSR_OP_ESR_Q: begin
					next_rsp_valid = 1'b1;
					next_rsp_value = esr;
				end
				SSR_OP_SRE_Q: begin
					next_rsp_valid = 1'b1;
					next_rsp_value = sre;
				end
				SSR_OP_ESE_Q: begin
					next_rsp_valid = 1'b1;
					next_rsp_value = ese;
				end
				SSR_OP_PSC_Q: begin
					next_rsp_valid = 1'b1;
					next_rsp_value = {7'h00, psc};
				end
				default: begin
					next_rsp_valid = 1'b0;
				end
			endcase
		end
		next_rsp_dec = to_dec(next_rsp_value);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_valid <= 1'b0;
			rsp_value <= 8'h00;
			rsp_dec <= 12'h000;
		end else begin
			rsp_valid <= next_rsp_valid;
			rsp_value <= next_rsp_value;
			rsp_dec <= next_rsp_dec;
		end
	end

	assign status_byte_o = stb;
	assign rsp_valid_o = rsp_valid;
	assign rsp_value_o = rsp_value;
	assign rsp_dec_o = rsp_dec;

	AST_ESR_LATCH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(esr[ESR_OPC_POS] && !do_cls && !do_esr_q) |=> esr[ESR_OPC_POS])
		else $error("event bit dropped without a clear");

	AST_ESR_READ_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(do_esr_q && ev == 8'h00) |=> esr == 8'h00 && rsp_value_o == $past(esr))
		else $error("event query did not return and clear");

	AST_CLS_KEEPS_MASKS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(do_cls && !power_on_i) |=> ese == $past(ese) && sre == $past(sre)
			&& esr == $past(ev))
		else $error("clear-status touched a mask");

	AST_STB_ZERO_BITS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(status_byte_o & STB_ZERO_MASK) == 8'h00)
		else $error("unused status byte bit set");

	AST_SMAV_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ser_not_empty_i && !smav_block && !do_cls) |=> status_byte_o[STB_SMAV_POS])
		else $error("message bit late");

	AST_SMAV_EMPTY: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!ser_not_empty_i |=> !status_byte_o[STB_SMAV_POS])
		else $error("message bit set with empty buffer");

	AST_QUENCH_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(status_byte_o[STB_QUENCH_POS] && !quench_reset_i && !do_cls)
			|=> status_byte_o[STB_QUENCH_POS])
		else $error("quench flag dropped");

	AST_ESB_SUMMARY: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		status_byte_o[STB_ESB_POS] == |(esr & ese))
		else $error("event summary out of step");

	AST_RQS_SUMMARY: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		status_byte_o[STB_RQS_POS] == |(status_byte_o[5:0] & sre[5:0]))
		else $error("status summary out of step");

	AST_MASK_ZERO: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(cmd_valid_i && cmd_op_i == SSR_OP_ESE_W && cmd_data_i == 8'h00)
			|=> ese == 8'h00)
		else $error("writing zero left the mask set");

	AST_PSC_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(power_on_i && psc) |=> ese == 8'h00 && sre == 8'h00
			&& esr[ESR_PON_POS])
		else $error("power-on clear failed");

	AST_QUERY_ANSWER: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		rsp_valid_o |-> rsp_dec_o[3:0] <= 4'h9 && rsp_dec_o[7:4] <= 4'h9
			&& 11'(rsp_dec_o[11:8]) * 11'h064
			+ 11'(rsp_dec_o[7:4]) * 11'h00a
			+ 11'(rsp_dec_o[3:0]) == 11'(rsp_value_o))
		else $error("decimal answer wrong");

	AST_CLS_CLEARS_STB: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(do_cls && ev == 8'h00 && !quench_detect_i)
			|=> status_byte_o == 8'h00)
		else $error("clear-status left a status bit set");

	AST_ESR_READ_ESB: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(do_esr_q && ev == 8'h00) |=> !status_byte_o[STB_ESB_POS])
		else $error("event read left the event summary set");

	AST_SRE_ZERO: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(cmd_valid_i && cmd_op_i == SSR_OP_SRE_W && cmd_data_i == 8'h00)
			|=> sre == 8'h00)
		else $error("writing zero left the status enable set");

	AST_ESE_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(cmd_valid_i && cmd_op_i == SSR_OP_ESE_W && !(power_on_i && psc))
			|=> ese == $past(cmd_data_i))
		else $error("event enable write lost");

	AST_PSC_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(power_on_i && !psc && !(cmd_valid_i
			&& (cmd_op_i == SSR_OP_ESE_W || cmd_op_i == SSR_OP_SRE_W)))
			|=> ese == $past(ese) && sre == $past(sre))
		else $error("masks lost on power-on without clear");

	AST_STB_QUERY: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(cmd_valid_i && cmd_op_i == SSR_OP_STB_Q) |=> rsp_valid_o
			&& rsp_value_o == $past(stb)
			&& stb[STB_RQS_POS] == |($past(next_stb[5:0]) & $past(next_sre[5:0])))
		else $error("status byte query wrong");

endmodule

// ### ssr_pkg.sv
// constants shared by the status reporting block and its keyword checker
package ssr_pkg;

	// width of every status, event and enable register
	localparam int unsigned REG_W = 8;

	// host commands that reach the status system
	typedef enum logic [3:0] {
		SSR_OP_NOP,
		SSR_OP_CLS,
		SSR_OP_STB_Q,
		SSR_OP_ESR_Q,
		SSR_OP_SRE_W,
		SSR_OP_SRE_Q,
		SSR_OP_ESE_W,
		SSR_OP_ESE_Q,
		SSR_OP_PSC_W,
		SSR_OP_PSC_Q
	} ssr_op_t;

	// status byte field positions
	localparam int unsigned STB_QUENCH_POS = 2;
	localparam int unsigned STB_SMAV_POS   = 3;
	localparam int unsigned STB_ESB_POS    = 5;
	localparam int unsigned STB_RQS_POS    = 6;

	// bits of the status byte that always read zero
	localparam logic [7:0] STB_ZERO_MASK = 8'h93;
	// bits of the status byte enable that can be set
	localparam logic [7:0] SRE_WR_MASK   = 8'h3c;

	// standard event field positions
	localparam int unsigned ESR_OPC_POS = 0;
	localparam int unsigned ESR_CME_POS = 5;
	localparam int unsigned ESR_PON_POS = 7;
	// standard event bits that can ever be set
	localparam logic [7:0] ESR_USED_MASK = 8'hbd;

	// values after reset
	localparam logic [7:0] STB_RESET = 8'h00;
	localparam logic [7:0] ESR_RESET = 8'h00;
	localparam logic [7:0] ESE_RESET = 8'h00;
	localparam logic [7:0] SRE_RESET = 8'h00;
	localparam logic       PSC_RESET = 1'b1;

	// keyword checker sizes
	localparam int unsigned KW_MAX   = 12;
	localparam int unsigned KW_IDX_W = 4;
	// lower case letters fold to upper case by clearing this bit
	localparam logic [7:0] ASCII_CASE_BIT = 8'h20;
	localparam logic [7:0] ASCII_LC_A     = 8'h61;
	localparam logic [7:0] ASCII_LC_Z     = 8'h7a;

endpackage

// ### ssr_kwchk.sv
// keyword spelling checker: full form or short form, case insensitive
`timescale 1ns/100ps
module ssr_kwchk #(
	parameter logic [8*ssr_pkg::KW_MAX-1:0] FULL_KW   = "CONFIGURE",
	parameter int unsigned                  FULL_LEN  = 9,
	parameter int unsigned                  SHORT_LEN = 4
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   ch_valid_i,
	input  wire logic [7:0]             ch_i,
	input  wire logic                   kw_end_i,
	output logic                        kw_ok_o,
	output logic                        kw_err_o
);
	import ssr_pkg::*;

	logic [KW_IDX_W-1:0] idx;
	logic                full_ok;
	logic                short_ok;
	logic                ok;
	logic                err;
	logic [KW_IDX_W-1:0] next_idx;
	logic                next_full_ok;
	logic                next_short_ok;
	logic                next_ok;
	logic                next_err;

	always_comb begin
		logic [7:0] up;
		logic [7:0] ref_ch;
		logic       accept;
		up = ch_i;
		ref_ch = 8'h00;
		accept = 1'b0;
		next_idx = idx;
		next_full_ok = full_ok;
		next_short_ok = short_ok;
		next_ok = 1'b0;
		next_err = 1'b0;
		if (ch_i >= ASCII_LC_A && ch_i <= ASCII_LC_Z) begin
			up = ch_i & ~ASCII_CASE_BIT;
		end
		if (32'(idx) < FULL_LEN) begin
			// the literal sits right-aligned, its first letter is highest
			ref_ch = FULL_KW[8*(FULL_LEN-32'(idx))-1 -: 8];
		end
		if (kw_end_i) begin
			// only the two documented spellings pass
			accept = (full_ok && 32'(idx) == FULL_LEN) ||
				(short_ok && 32'(idx) == SHORT_LEN);
			next_ok = accept;
			next_err = ~accept;
			next_idx = '0;
			next_full_ok = 1'b1;
			next_short_ok = 1'b1;
		end else if (ch_valid_i) begin
			if (32'(idx) >= FULL_LEN || up != ref_ch) begin
				next_full_ok = 1'b0;
			end
			if (32'(idx) >= SHORT_LEN || up != ref_ch) begin
				next_short_ok = 1'b0;
			end
			if (idx != {KW_IDX_W{1'b1}}) begin
				next_idx = idx + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx <= '0;
			full_ok <= 1'b1;
			short_ok <= 1'b1;
			ok <= 1'b0;
			err <= 1'b0;
		end else begin
			idx <= next_idx;
			full_ok <= next_full_ok;
			short_ok <= next_short_ok;
			ok <= next_ok;
			err <= next_err;
		end
	end

	assign kw_ok_o = ok;
	assign kw_err_o = err;

	AST_KW_VERDICT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		kw_end_i |=> (kw_ok_o ^ kw_err_o) && idx == '0)
		else $error("keyword end gave no single verdict");

endmodule

// ### ssr_host_model.sv
// host side model that sends keyword characters to the parser
`timescale 1ns/100ps
module ssr_host_model (
	input  wire logic       ref_clk_i,
	output logic            ch_valid_o,
	output logic [7:0]      ch_o,
	output logic            kw_end_o
);
	initial begin
		ch_valid_o = 1'b0;
		ch_o = 8'h00;
		kw_end_o = 1'b0;
	end
	// one character per cycle, then a one-cycle kw_end_o pulse marks the keyword end
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			ch_valid_o = 1'b1;
			ch_o = s[i];
			@(posedge ref_clk_i);
			#2;
		end
		ch_valid_o = 1'b0;
		// released character line shows the inverse of the last value
		ch_o = ~ch_o;
		// a one-cycle pulse on kw_end_o ends it, no delimiter character is sent
		kw_end_o = 1'b1;
		@(posedge ref_clk_i);
		#2;
		kw_end_o = 1'b0;
	endtask
endmodule

// ### ssr_status_tb_top.sv
// self-checking testbench for the status reporting block
`timescale 1ns/100ps
module ssr_status_tb_top;
	import ssr_pkg::*;
	logic             ref_clk_i = 1'b0;
	logic             resetn_i = 1'b0;
	logic             cmd_valid_i = 1'b0;
	ssr_op_t          cmd_op_i = SSR_OP_NOP;
	logic [7:0]       cmd_data_i = 8'h00;
	logic [7:0]       event_i = 8'h00;
	logic             power_on_i = 1'b0;
	logic             quench_detect_i = 1'b0;
	logic             quench_reset_i = 1'b0;
	logic             ser_not_empty_i = 1'b0;
	logic             ch_valid;
	logic [7:0]       ch;
	logic             kw_end;
	logic [7:0]       status_byte_o;
	logic             rsp_valid_o;
	logic [7:0]       rsp_value_o;
	logic [11:0]      rsp_dec_o;
	logic             r_valid;
	logic [7:0]       r_val;
	logic [11:0]      r_dec;
	int               fails = 0;
	int               check_count = 0;
	string            kws [5] = '{"CONF", "CONFIGURE", "conf", "CONFI", "CON"};
	logic [7:0]       kexp [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h20};

	always #10 ref_clk_i = ~ref_clk_i;

	ssr_status u_dut (
		.ref_clk_i       (ref_clk_i),
		.resetn_i        (resetn_i),
		.cmd_valid_i     (cmd_valid_i),
		.cmd_op_i        (cmd_op_i),
		.cmd_data_i      (cmd_data_i),
		.event_i         (event_i),
		.power_on_i      (power_on_i),
		.quench_detect_i (quench_detect_i),
		.quench_reset_i  (quench_reset_i),
		.ser_not_empty_i (ser_not_empty_i),
		.ch_valid_i      (ch_valid),
		.ch_i            (ch),
		.kw_end_i        (kw_end),
		.status_byte_o   (status_byte_o),
		.rsp_valid_o     (rsp_valid_o),
		.rsp_value_o     (rsp_value_o),
		.rsp_dec_o       (rsp_dec_o)
	);

	ssr_host_model u_host (
		.ref_clk_i  (ref_clk_i),
		.ch_valid_o (ch_valid),
		.ch_o       (ch),
		.kw_end_o   (kw_end)
	);

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask

	// one command, answer captured in the cycle after it
	task automatic cmd(input ssr_op_t op, input logic [7:0] d);
		cmd_valid_i = 1'b1;
		cmd_op_i = op;
		cmd_data_i = d;
		tick(1);
		cmd_valid_i = 1'b0;
		cmd_op_i = SSR_OP_NOP;
		cmd_data_i = ~d;
		r_valid = rsp_valid_o;
		r_val = rsp_value_o;
		r_dec = rsp_dec_o;
		tick(1);
	endtask

	task automatic q(input ssr_op_t op, input logic [7:0] exp);
		cmd(op, 8'h00);
		chk({11'h000, r_valid}, 12'h001);
		chk({4'h0, r_val}, {4'h0, exp});
	endtask

	task automatic ev(input logic [7:0] v);
		event_i = v;
		tick(1);
		event_i = 8'h00;
		tick(1);
	endtask

	task automatic pwr();
		power_on_i = 1'b1;
		tick(1);
		power_on_i = 1'b0;
		tick(1);
	endtask

	task automatic stb(input logic [7:0] exp);
		chk({4'h0, status_byte_o}, {4'h0, exp});
	endtask

	initial begin
		#200000;
		fails++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge ref_clk_i);
		#2;
		resetn_i = 1'b1;
		stb(8'h00);
		q(SSR_OP_ESR_Q, 8'h00);
		q(SSR_OP_ESE_Q, 8'h00);
		q(SSR_OP_SRE_Q, 8'h00);
		q(SSR_OP_PSC_Q, 8'h01);
		ev(8'hff);
		ev(8'hff);
		q(SSR_OP_ESR_Q, 8'hbd);
		chk(r_dec, 12'h189);
		q(SSR_OP_ESR_Q, 8'h00);
		cmd(SSR_OP_ESE_W, 8'h20);
		q(SSR_OP_ESE_Q, 8'h20);
		cmd(SSR_OP_SRE_W, 8'hff);
		q(SSR_OP_SRE_Q, 8'h3c);
		ev(8'h04);
		stb(8'h00);
		ev(8'h20);
		stb(8'h60);
		q(SSR_OP_STB_Q, 8'h60);
		stb(8'h60);
		q(SSR_OP_ESR_Q, 8'h24);
		stb(8'h00);
		ev(8'h20);
		cmd(SSR_OP_CLS, 8'h00);
		stb(8'h00);
		q(SSR_OP_ESE_Q, 8'h20);
		q(SSR_OP_ESR_Q, 8'h00);
		quench_detect_i = 1'b1;
		tick(1);
		quench_detect_i = 1'b0;
		tick(1);
		stb(8'h44);
		tick(6);
		q(SSR_OP_STB_Q, 8'h44);
		stb(8'h44);
		quench_reset_i = 1'b1;
		tick(1);
		quench_reset_i = 1'b0;
		tick(1);
		stb(8'h00);
		ser_not_empty_i = 1'b1;
		tick(1);
		stb(8'h48);
		tick(4);
		stb(8'h48);
		ser_not_empty_i = 1'b0;
		tick(1);
		stb(8'h00);
		cmd(SSR_OP_PSC_W, 8'h00);
		q(SSR_OP_PSC_Q, 8'h00);
		pwr();
		q(SSR_OP_ESE_Q, 8'h20);
		q(SSR_OP_SRE_Q, 8'h3c);
		q(SSR_OP_ESR_Q, 8'h80);
		cmd(SSR_OP_ESE_W, 8'h00);
		q(SSR_OP_ESE_Q, 8'h00);
		cmd(SSR_OP_PSC_W, 8'h01);
		pwr();
		q(SSR_OP_SRE_Q, 8'h00);
		q(SSR_OP_ESR_Q, 8'h80);
		// clear-status with data waiting holds bit 3 low until empty
		ser_not_empty_i = 1'b1;
		tick(1);
		stb(8'h08);
		cmd(SSR_OP_CLS, 8'h00);
		stb(8'h00);
		ser_not_empty_i = 1'b0;
		tick(1);
		stb(8'h00);
		ser_not_empty_i = 1'b1;
		tick(1);
		stb(8'h08);
		ser_not_empty_i = 1'b0;
		tick(1);
		for (int i = 0; i < 5; i++) begin
			u_host.send(kws[i]);
			tick(3);
			q(SSR_OP_ESR_Q, kexp[i]);
		end
		// second reset in mid-run brings the setting back to 1
		cmd(SSR_OP_PSC_W, 8'h00);
		resetn_i = 1'b0;
		tick(2);
		resetn_i = 1'b1;
		stb(8'h00);
		q(SSR_OP_PSC_Q, 8'h01);
		q(SSR_OP_ESE_Q, 8'h00);
		summarize();
	end
endmodule
